/* File: rtl/pidpc_controller.sv */
// PID process controller with register port and speed command output
`timescale 1ns/10ps
`include "pidpc_consts.svh"

module pidpc_controller (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire pidpc_pkg::pidpc_bus_t bus,
  output logic [15:0] rdata,
  // Pins and sampled values
  input wire pidpc_pkg::pidpc_din_t din,
  input wire logic [15:0] firstAnalogInput,
  input wire logic [15:0] motorSpeed,
  input wire logic sampleTick,
  // Results
  output logic [15:0] speedCommand,
  output logic [15:0] controllerOutput,
  output logic manualMode
);
  import pidpc_pkg::*;

  pidpc_run_t runState_r;
  logic [15:0] autoSp_r;
  logic [15:0] selSp_r [4];
  logic [15:0] manSp_r, kp_r, ki_r, kd_r, ta_r, minSpd_r, maxSpd_r;
  logic [1:0] srcSel_r;
  logic [2:0] selMode_r;
  logic reverse_r;
  logic [2:0] din1_r, din2_r;
  logic [15:0] pv_r;
  logic signed [31:0] integ_r, errPrev_r, outAcc_r;
  logic [15:0] rdata_r, speed_r, out_r;
  logic minReached_r;

  // Clamp a write into the legal setpoint span
  function automatic logic [15:0] clampSp(input logic [15:0] v);
    if ($signed(v) > `PIDPC_SP_MAX) return `PIDPC_SP_MAX;
    if ($signed(v) < `PIDPC_SP_MIN) return 16'(`PIDPC_SP_MIN);
    return v;
  endfunction : clampSp

  // Saturate to 0..1000 tenths
  function automatic logic signed [31:0] sat(input logic signed [31:0] v);
    if (v < 0) return 32'sh0000_0000;
    if (v > `PIDPC_OUT_MAX) return `PIDPC_OUT_MAX;
    return v;
  endfunction : sat

  function automatic logic wrAt(input pidpc_bus_t b, input logic [4:0] a);
    return b.wr && (b.addr == a);
  endfunction : wrAt

  // Digital inputs are asynchronous pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      din1_r <= 3'h0;
      din2_r <= 3'h0;
    end else begin
      din1_r <= {din.manualAuto, din.selA, din.selB};
      din2_r <= din1_r;
    end
  end

  logic manualNow, selA, selB;
  assign manualNow = !din2_r[2];
  assign selA = din2_r[1];
  assign selB = din2_r[0];

  // Application run control
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      runState_r <= PIDPC_STOPPED;
    end else if (runState_r == PIDPC_STOPPED &&
                 wrAt(bus, `PIDPC_A_RUNCMD) &&
                 bus.wdata == `PIDPC_CMD_EXEC) begin
      runState_r <= PIDPC_RUNNING;
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      manSp_r <= `PIDPC_ZERO16;
      kp_r <= `PIDPC_KP_RST;
      ki_r <= `PIDPC_KI_RST;
      kd_r <= `PIDPC_ZERO16;
      ta_r <= `PIDPC_TA_RST;
      minSpd_r <= `PIDPC_ZERO16;
      maxSpd_r <= `PIDPC_ZERO16;
      srcSel_r <= `PIDPC_SRC_PANEL;
      selMode_r <= 3'h0;
      reverse_r <= 1'b0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        `PIDPC_A_MANSP: manSp_r <= bus.wdata;
        `PIDPC_A_KP: kp_r <= bus.wdata;
        `PIDPC_A_KI: ki_r <= bus.wdata;
        `PIDPC_A_KD: kd_r <= bus.wdata;
        `PIDPC_A_TA: ta_r <= (bus.wdata == `PIDPC_ZERO16) ?
                              ta_r : bus.wdata;
        `PIDPC_A_MINSPD: minSpd_r <= bus.wdata;
        `PIDPC_A_MAXSPD: maxSpd_r <= bus.wdata;
        `PIDPC_A_SRCSEL: srcSel_r <= bus.wdata[1:0];
        `PIDPC_A_SELMODE: selMode_r <= bus.wdata[2:0];
        `PIDPC_A_ACTION: reverse_r <= bus.wdata[0];
        default: ;
      endcase
    end
  end

  // Four selectable setpoints
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gSp
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          selSp_r[gi] <= `PIDPC_SP_RST;
        end else if (wrAt(bus, 5'(`PIDPC_A_SP1 + gi))) begin
          selSp_r[gi] <= clampSp(bus.wdata);
        end
      end
    end
  endgenerate

  logic digSel;
  logic [15:0] pickedSp;
  assign digSel = (selMode_r >= `PIDPC_SEL_LO) &&
                  (selMode_r <= `PIDPC_SEL_HI);
  assign pickedSp = selSp_r[{selB, selA}];

  // Automatic setpoint: stored, or mirrors the setpoint in use
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      autoSp_r <= `PIDPC_SP_RST;
    end else if (srcSel_r != `PIDPC_SRC_PANEL) begin
      if (digSel) autoSp_r <= pickedSp;
    end else if (wrAt(bus, `PIDPC_A_AUTOSP)) begin
      autoSp_r <= clampSp(bus.wdata);
    end
  end

  // Process variable and minimum speed from outside samples
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pv_r <= `PIDPC_ZERO16;
      minReached_r <= 1'b0;
    end else begin
      pv_r <= firstAnalogInput;
      minReached_r <= (motorSpeed >= minSpd_r);
    end
  end

  // Error and PID terms
  logic signed [31:0] err, kpS, kiTa, kdTa, term, yNew;
  always_comb begin
    err = reverse_r ? 32'($signed(pv_r)) - 32'($signed(autoSp_r))
                    : 32'($signed(autoSp_r)) - 32'($signed(pv_r));
    kpS = 32'($signed({16'h0000, kp_r}));
    // Ki*Ta in hundredths; Kd/Ta in hundredths
    kiTa = 32'($signed({16'h0000, ki_r})) * 32'($signed({16'h0000, ta_r}))
           / `PIDPC_TA_UNIT;
    kdTa = 32'($signed({16'h0000, kd_r})) * `PIDPC_TA_UNIT
           / 32'($signed({16'h0000, ta_r}));
    term = ((`PIDPC_GAIN_FRAC + kiTa + kdTa) * err
            - kdTa * errPrev_r) / `PIDPC_GAIN_FRAC;
    yNew = integ_r + kpS * term / `PIDPC_GAIN_FRAC
           * `PIDPC_OUT_SCALE / `PIDPC_GAIN_FRAC;
  end

  logic runAuto;
  assign runAuto = (runState_r == PIDPC_RUNNING) && !manualNow &&
                   minReached_r;

  // One evaluation per tick, then state update
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      integ_r <= 32'sh0000_0000;
      errPrev_r <= 32'sh0000_0000;
      outAcc_r <= 32'sh0000_0000;
    end else if (sampleTick && runState_r == PIDPC_RUNNING) begin
      errPrev_r <= err;
      if (manualNow) begin
        // Manual output preloads the integral for a bumpless switch
        outAcc_r <= sat(32'($signed({16'h0000, manSp_r})));
        integ_r <= sat(32'($signed({16'h0000, manSp_r})));
      end else if (runAuto) begin
        outAcc_r <= sat(yNew);
        integ_r <= sat(yNew);
      end
    end
  end

  // Linear speed map from tenths of a percent
  logic [31:0] span, spd;
  always_comb begin
    span = (maxSpd_r > minSpd_r) ? 32'(maxSpd_r - minSpd_r) : 32'h0000_0000;
    spd = 32'(minSpd_r) + span * 32'(outAcc_r) / 32'(`PIDPC_OUT_MAX);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      speed_r <= `PIDPC_ZERO16;
      out_r <= `PIDPC_ZERO16;
    end else begin
      speed_r <= spd[15:0];
      out_r <= outAcc_r[15:0];
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= `PIDPC_ZERO16;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `PIDPC_A_RUNSTATE: rdata_r <= (runState_r == PIDPC_RUNNING) ?
            `PIDPC_ST_RUNNING : `PIDPC_ST_STOPPED;
        `PIDPC_A_VERSION: rdata_r <= `PIDPC_VERSION;
        `PIDPC_A_AUTOSP: rdata_r <= autoSp_r;
        `PIDPC_A_SP1, `PIDPC_A_SP2, `PIDPC_A_SP3, `PIDPC_A_SP4:
          rdata_r <= selSp_r[bus.addr[1:0]];
        `PIDPC_A_PV: rdata_r <= pv_r;
        `PIDPC_A_OUT: rdata_r <= out_r;
        `PIDPC_A_MANSP: rdata_r <= manSp_r;
        `PIDPC_A_SRCSEL: rdata_r <= {14'h0000, srcSel_r};
        `PIDPC_A_KP: rdata_r <= kp_r;
        `PIDPC_A_KI: rdata_r <= ki_r;
        `PIDPC_A_KD: rdata_r <= kd_r;
        `PIDPC_A_TA: rdata_r <= ta_r;
        `PIDPC_A_SELMODE: rdata_r <= {13'h0000, selMode_r};
        `PIDPC_A_ACTION: rdata_r <= {15'h0000, reverse_r};
        `PIDPC_A_MINSPD: rdata_r <= minSpd_r;
        `PIDPC_A_MAXSPD: rdata_r <= maxSpd_r;
        `PIDPC_A_SPEED: rdata_r <= speed_r;
        `PIDPC_A_STATUS: rdata_r <= {14'h0000, !manualNow, minReached_r};
        default: rdata_r <= `PIDPC_ZERO16;
      endcase
    end else begin
      rdata_r <= `PIDPC_ZERO16;
    end
  end

  logic manual_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) manual_r <= 1'b1;
    else manual_r <= manualNow;
  end

  assign rdata = rdata_r;
  assign speedCommand = speed_r;
  assign controllerOutput = out_r;
  assign manualMode = manual_r;

  // Checks
  start_cmd_a: assert property (@(posedge clk) disable iff (!nrst)
    (runState_r == PIDPC_STOPPED && bus.wr && bus.addr == `PIDPC_A_RUNCMD
     && bus.wdata == `PIDPC_CMD_EXEC) |=> runState_r == PIDPC_RUNNING)
    else $error("run command did not start");
  run_state_a: assert property (@(posedge clk) disable iff (!nrst)
    (bus.rd && bus.addr == `PIDPC_A_RUNSTATE) |=>
      (rdata == `PIDPC_ST_RUNNING || rdata == `PIDPC_ST_STOPPED))
    else $error("bad run state code");
  out_range_a: assert property (@(posedge clk) disable iff (!nrst)
    outAcc_r >= 0 && outAcc_r <= `PIDPC_OUT_MAX)
    else $error("output out of range");
  manual_out_a: assert property (@(posedge clk) disable iff (!nrst)
    (sampleTick && runState_r == PIDPC_RUNNING && manualNow) |=>
      outAcc_r == sat(32'($signed({16'h0000, $past(manSp_r)}))))
    else $error("manual output not applied");
  min_speed_a: assert property (@(posedge clk) disable iff (!nrst)
    (!minReached_r && !manualNow) |=> $stable(integ_r))
    else $error("regulated below minimum speed");
  err_store_a: assert property (@(posedge clk) disable iff (!nrst)
    (sampleTick && runState_r == PIDPC_RUNNING) |=> errPrev_r == $past(err))
    else $error("previous error not stored");
  speed_map_a: assert property (@(posedge clk) disable iff (!nrst)
    (outAcc_r == 0 && $past(outAcc_r) == 0 && $stable(minSpd_r)) |=>
      speed_r == $past(minSpd_r))
    else $error("zero output not at minimum speed");
  sp_limit_a: assert property (@(posedge clk) disable iff (!nrst)
    $signed(selSp_r[0]) <= `PIDPC_SP_MAX &&
    $signed(selSp_r[0]) >= `PIDPC_SP_MIN)
    else $error("setpoint out of range");
  version_a: assert property (@(posedge clk) disable iff (!nrst)
    (bus.rd && bus.addr == `PIDPC_A_VERSION) |=> rdata == `PIDPC_VERSION)
    else $error("version wrong");
endmodule : pidpc_controller

/* File: inc/pidpc_consts.svh */
// Constants for the PID process controller: register map, resets, limits
`ifndef PIDPC_CONSTS_SVH
`define PIDPC_CONSTS_SVH

`define PIDPC_A_RUNSTATE 5'h00
`define PIDPC_A_RUNCMD 5'h01
`define PIDPC_A_VERSION 5'h02
`define PIDPC_A_AUTOSP 5'h03
`define PIDPC_A_SP1 5'h04
`define PIDPC_A_SP2 5'h05
`define PIDPC_A_SP3 5'h06
`define PIDPC_A_SP4 5'h07
`define PIDPC_A_PV 5'h08
`define PIDPC_A_OUT 5'h09
`define PIDPC_A_MANSP 5'h0A
`define PIDPC_A_SRCSEL 5'h0B
`define PIDPC_A_KP 5'h0C
`define PIDPC_A_KI 5'h0D
`define PIDPC_A_KD 5'h0E
`define PIDPC_A_TA 5'h0F
`define PIDPC_A_SELMODE 5'h10
`define PIDPC_A_ACTION 5'h11
`define PIDPC_A_MINSPD 5'h12
`define PIDPC_A_MAXSPD 5'h13
`define PIDPC_A_SPEED 5'h14
`define PIDPC_A_STATUS 5'h15

// Run state codes
`define PIDPC_ST_STOPPED 16'h0003
`define PIDPC_ST_RUNNING 16'h0004
`define PIDPC_CMD_EXEC 16'h0001

// Setpoints in hundredths of engineering units
`define PIDPC_SP_MAX 16'sh270F
`define PIDPC_SP_MIN (-16'sh270F)
`define PIDPC_SP_RST 16'h00C8
// Version in hundredths; 90.00 is the ceiling, value arbitrary
`define PIDPC_VERSION 16'h0064
// Output in tenths of a percent
`define PIDPC_OUT_MAX 32'sh0000_03E8
`define PIDPC_OUT_SCALE 32'sh0000_000A
// Gains in hundredths, period in milliseconds
`define PIDPC_GAIN_FRAC 32'sh0000_0064
`define PIDPC_TA_UNIT 32'sh0000_03E8
`define PIDPC_KP_RST 16'h0064
`define PIDPC_KI_RST 16'h01F4
`define PIDPC_TA_RST 16'h0064
`define PIDPC_SRC_PANEL 2'h0
`define PIDPC_SEL_LO 3'h4
`define PIDPC_SEL_HI 3'h6
`define PIDPC_ZERO16 16'h0000

`endif

/* File: inc/pidpc_pkg.sv */
// Types for the PID process controller
package pidpc_pkg;
  typedef enum logic [1:0] {PIDPC_STOPPED, PIDPC_RUNNING} pidpc_run_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pidpc_bus_t;

  typedef struct packed {
    logic manualAuto;
    logic selA;
    logic selB;
  } pidpc_din_t;
endpackage : pidpc_pkg

/* File: dv/pidpc_plant.sv */
// Motor and process sensor seen from the controller's speed output
`timescale 1ns/10ps
module pidpc_plant (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Drive side
  input wire logic [15:0] speedCommand,
  input wire logic [15:0] pvSet,
  output logic [15:0] motorSpeed,
  output logic [15:0] firstAnalogInput
);
  // Slow ramp, so the minimum-speed gate is still shut at the first tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      motorSpeed <= 16'h0000;
    end else if (motorSpeed < speedCommand) begin
      motorSpeed <= motorSpeed + 16'h0001;
    end else if (motorSpeed > speedCommand) begin
      motorSpeed <= motorSpeed - 16'h0001;
    end
  end
  assign firstAnalogInput = pvSet;
endmodule : pidpc_plant

/* File: dv/pid_process_controller_bench.sv */
// Self-checking bench for the PID process controller
`timescale 1ns/10ps
`include "pidpc_consts.svh"
module pid_process_controller_bench;
  import pidpc_pkg::*;
  logic clk, nrst, sampleTick, manualMode;
  pidpc_bus_t bus;
  pidpc_din_t din;
  logic [15:0] rdata, motorSpeed, firstAnalogInput, pvSet, v;
  logic [15:0] speedCommand, controllerOutput;
  int n_mismatch, comparisons, integ, ep, sp, kp, ki, kd, ta, rev;
  int minSpd, maxSpd, manSp, i, m;
  int spv[4];
  int pvs[6] = '{100, 100, 0, -9999, 300, 300};
  logic [31:0] seed = 32'h0000_d1df;

  pidpc_controller pidpc_controller_i (.clk(clk), .nrst(nrst), .bus(bus),
    .rdata(rdata), .din(din), .firstAnalogInput(firstAnalogInput),
    .motorSpeed(motorSpeed), .sampleTick(sampleTick),
    .speedCommand(speedCommand), .controllerOutput(controllerOutput),
    .manualMode(manualMode));
  pidpc_plant pidpc_plant_i (.clk(clk), .nrst(nrst),
    .speedCommand(speedCommand), .pvSet(pvSet), .motorSpeed(motorSpeed),
    .firstAnalogInput(firstAnalogInput));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd

  // One sample of the reference controller, gains in hundredths, Ta in ms
  // Fixed point: gains and Ki*Ta, Kd/Ta in hundredths, output in tenths
  task automatic tick();
    int e, pvi, kiTa, kdTa, term;
    @(posedge clk);
    sampleTick <= 1'b1;
    pvi = int'($signed(pvSet));
    e = rev ? pvi - sp : sp - pvi;
    @(posedge clk);
    sampleTick <= 1'b0;
    kiTa = ki * ta / 1000;
    kdTa = kd * 1000 / ta;
    term = ((100 + kiTa + kdTa) * e - kdTa * ep) / 100;
    if (!din.manualAuto) begin
      integ = manSp;
    end else if (motorSpeed >= minSpd) begin
      integ = integ + kp * term / 100 * 10 / 100;
    end
    integ = integ > 1000 ? 1000 : (integ < 0 ? 0 : integ);
    ep = e;
    repeat (3) @(posedge clk);
    #1 check(controllerOutput, integ[15:0]);
    e = minSpd + (maxSpd - minSpd) * integ / 1000;
    check(speedCommand, 16'(e));
  endtask : tick

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs about 830 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    nrst = 1'b0;
    bus = '0;
    din = '0;
    sampleTick = 1'b0;
    pvSet = 16'h0064;
    {n_mismatch, comparisons, integ, ep, rev, minSpd, maxSpd, manSp} = '0;
    {kp, ki, kd, ta, sp} = {32'd100, 32'd500, 32'd0, 32'd100, 32'd200};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`PIDPC_A_RUNSTATE);
    check(v, `PIDPC_ST_STOPPED);
    wr(`PIDPC_A_VERSION, 16'h1234);
    rd(`PIDPC_A_VERSION);
    check(v, `PIDPC_VERSION);
    rd(`PIDPC_A_SP4);
    check(v, `PIDPC_SP_RST);
    rd(5'h1F);
    check(v, 16'h0000);
    wr(`PIDPC_A_SP1, 16'h7FFF);
    rd(`PIDPC_A_SP1);
    check(v, 16'h270F);
    wr(`PIDPC_A_SP1, 16'h8000);
    rd(`PIDPC_A_SP1);
    check(v, 16'hD8F1);
    $display("reset values and limits done");
    {minSpd, maxSpd, kd} = {32'd500, 32'd1500, 32'd10};
    wr(`PIDPC_A_MINSPD, 16'h01F4);
    wr(`PIDPC_A_MAXSPD, 16'h05DC);
    wr(`PIDPC_A_KD, 16'h000A);
    wr(`PIDPC_A_RUNCMD, `PIDPC_CMD_EXEC);
    rd(`PIDPC_A_RUNSTATE);
    check(v, `PIDPC_ST_RUNNING);
    @(posedge clk);
    din.manualAuto <= 1'b1;
    repeat (5) @(posedge clk);
    #1 check({15'h0000, manualMode}, 16'h0000);
    tick();
    repeat (600) @(posedge clk);
    for (i = 0; i < 6; i++) begin
      if (i == 4) begin
        rev = 1;
        wr(`PIDPC_A_ACTION, 16'h0001);
        kp = 200;
        wr(`PIDPC_A_KP, 16'h00C8);
      end
      @(posedge clk);
      pvSet <= 16'(pvs[i]);
      rd(`PIDPC_A_PV);
      check(v, 16'(pvs[i]));
      tick();
    end
    $display("automatic regulation done");
    @(posedge clk);
    din.manualAuto <= 1'b0;
    repeat (5) @(posedge clk);
    #1 check({15'h0000, manualMode}, 16'h0001);
    for (i = 0; i < 3; i++) begin
      manSp = int'(rnd() % 1001);
      wr(`PIDPC_A_MANSP, 16'(manSp));
      tick();
    end
    $display("manual mode done");
    for (i = 0; i < 4; i++) begin
      spv[i] = int'(rnd() % 19999) - 9999;
      wr(5'(`PIDPC_A_SP1 + i), 16'(spv[i]));
    end
    wr(`PIDPC_A_SRCSEL, 16'h0001);
    for (m = 4; m < 7; m++) begin
      wr(`PIDPC_A_SELMODE, 16'(m));
      for (i = 0; i < 4; i++) begin
        @(posedge clk);
        {din.selB, din.selA} <= 2'(i);
        repeat (5) @(posedge clk);
        rd(`PIDPC_A_AUTOSP);
        check(v, 16'(spv[i]));
      end
    end
    $display("setpoint selection done");
    summarize();
  end
endmodule : pid_process_controller_bench
